// File: design/psc_pkg.sv
// Package of constants and types for the pack supervisor control block
// Functional notes
// - Sample the system present pin once per second; low means host present.
// - Falling edge on emergency off input turns both switch drives off.
// - Further falling edge or configurable timeout turns both drives on again.
// - Balancing allowed up to six series cells, while charging or at rest.
// - Internal bypass mode may balance several cells at once.
// - External balancing mode balances at most one cell at a time.
// - While charging, balance a cell only above the voltage threshold.
// - Positive sense voltage is charge, negative is discharge.
// - Sense samples are integrated continuously into a signed charge counter.
// - Request a refresh of every cell voltage once per second.
// - Lifetime log written every ten hours, only when RAM differs.
// - Balance time, runtime, temperature-range log written every two hours if different.
// - Enter bus off when both bus lines stay low two seconds or longer.
// - Leave bus off when either line goes high; resume within one millisecond.
// - One internal and four external temperature inputs, each enabled and assigned.
// - Inhibit or suspend charging while pack temperature is out of range.
// - Broadcast charge current and voltage for active temperature range.
// - Standard range split in two; current varies with cell voltage.
// - Flag charging faults and show status on charge and discharge alarms.
// - Drive three to five segment display: capacity or failure code.
// - Bus master operation and packet error checking are selectable.
package psc_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned TICK_NS       = 1000000;
  localparam int unsigned MS_CYC_DEF    = TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned SEC_MS        = 1000;
  localparam int unsigned BUSOFF_S      = 2;
  localparam int unsigned BUSOFF_MS     = BUSOFF_S * SEC_MS;
  localparam int unsigned LOG_FAST_H    = 2;
  localparam int unsigned LOG_LIFE_H    = 10;
  localparam int unsigned HOUR_S        = 3600;
  localparam int unsigned LOG_FAST_S    = LOG_FAST_H * HOUR_S;
  localparam int unsigned LOG_LIFE_S    = LOG_LIFE_H * HOUR_S;
  localparam int unsigned CNT_W         = 24;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int unsigned MAX_CELLS = 6;
  localparam int unsigned N_TEMP    = 5;
  localparam int unsigned N_SEG     = 5;
  localparam int unsigned SV_W      = 16;
  localparam int unsigned ACC_W     = 32;
  localparam int unsigned PCT_FULL  = 100;

  // ----------------------------------------
  // Register byte addresses
  // ----------------------------------------
  localparam logic [7:0] A_CTRL     = 8'h00;
  localparam logic [7:0] A_STATUS   = 8'h04;
  localparam logic [7:0] A_EOFF_TMO = 8'h08;
  localparam logic [7:0] A_BAL_REQ  = 8'h0c;
  localparam logic [7:0] A_TEMP_CFG = 8'h10;
  localparam logic [7:0] A_CUR_LO   = 8'h14;
  localparam logic [7:0] A_CUR_HI   = 8'h18;
  localparam logic [7:0] A_VOLT     = 8'h1c;
  localparam logic [7:0] A_FAIL     = 8'h20;
  localparam logic [7:0] A_CHARGE   = 8'h24;

  // ----------------------------------------
  // Reset values and field positions
  // ----------------------------------------
  localparam logic [15:0] EOFF_TMO_RST = 16'h2710;
  localparam logic [2:0]  CELLS_RST    = 3'h6;
  localparam logic [2:0]  SEGS_RST     = 3'h5;
  localparam int unsigned ST_FAULT     = 8;

  typedef enum logic [0:0] {EO_RUN, EO_OFF} psc_eoff_t;

  typedef struct packed {
    logic       ext_bal;
    logic       bcast_en;
    logic       pec_en;
    logic       master_en;
    logic       pf_mode;
    logic [2:0] cells;
    logic [2:0] segs;
  } psc_ctrl_t;

  typedef struct packed {
    logic       pready;
    logic [31:0] prdata;
    logic       pslverr;
  } psc_apb_rsp_t;

endpackage

// File: design/psc_sync.sv
// Two-stage synchroniser for asynchronous pins
`timescale 1ns/100ps
module psc_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         sys_clk, // System clock
  input  wire logic         rst_n,   // Async reset, active low
  input  wire logic [W-1:0] d,       // Asynchronous inputs
  output logic      [W-1:0] q        // Synchronised outputs
);
  logic [W-1:0] meta_r;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// File: design/psc_top.sv
// Pack supervisor control: timers, switch drives, balancing, gauging, APB
`timescale 1ns/100ps
module psc_top #(
  parameter int unsigned MS_CYC     = psc_pkg::MS_CYC_DEF,
  parameter int unsigned LOG_FAST_S = psc_pkg::LOG_FAST_S,
  parameter int unsigned LOG_LIFE_S = psc_pkg::LOG_LIFE_S
) (
  input  wire logic        sys_clk,                // System clock
  input  wire logic        rst_n,                  // Async reset, active low
  input  wire logic [7:0]  paddr,                  // APB address
  input  wire logic        psel,                   // APB select
  input  wire logic        penable,                // APB enable
  input  wire logic        pwrite,                 // APB write
  input  wire logic [31:0] pwdata,                 // APB write data
  output logic             pready,                 // APB ready
  output logic      [31:0] prdata,                 // APB read data
  output logic             pslverr,                // APB error
  input  wire logic        system_present_input,   // Pin, low when host present
  input  wire logic        emergency_off_input,    // Pin, push button
  input  wire logic        bus_clock_line,         // Bus clock pin level
  input  wire logic        bus_data_line,          // Bus data pin level
  input  wire logic [15:0] sense_voltage,          // Signed sense sample
  input  wire logic        sense_valid,            // Sample strobe
  input  wire logic [5:0]  cell_over_thr,          // Cell above balance threshold
  input  wire logic        temp_in_range,          // Pack temp in charge range
  input  wire logic [1:0]  temp_range,             // Active temperature subrange
  input  wire logic [6:0]  capacity_pct,           // Remaining capacity percent
  input  wire logic        log_life_dirty,         // Lifetime RAM differs
  input  wire logic        log_fast_dirty,         // Fast log RAM differs
  output logic             charge_switch_drive,    // Charge switch on
  output logic             discharge_switch_drive, // Discharge switch on
  output logic             system_present,         // Host present
  output logic      [5:0]  bal_en,                 // Cell bypass enables
  output logic             cell_scan_req,          // Cell voltage refresh pulse
  output logic             log_life_wr,            // Lifetime log write pulse
  output logic             log_fast_wr,            // Fast log write pulse
  output logic             bus_off,                // Bus off state
  output logic      [4:0]  temp_en,                // Temperature input enables
  output logic      [4:0]  temp_is_fet,            // Input used for switch temp
  output logic             bcast_req,              // Broadcast request pulse
  output logic      [15:0] bcast_current,          // Requested charge current
  output logic      [15:0] bcast_voltage,          // Requested charge voltage
  output logic             charge_alarm,           // Charge alarm
  output logic             discharge_alarm,        // Discharge alarm
  output logic      [4:0]  led_seg,                // Display segments
  output logic             bus_master_en,          // Bus master enabled
  output logic             pec_en,                 // Packet error check enabled
  output logic             charge_active,          // Charge flowing
  output logic             discharge_active        // Discharge flowing
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    psc_pkg::psc_apb_rsp_t  apb;
    psc_pkg::psc_ctrl_t     ctrl;
    logic [15:0]            eoff_tmo;
    logic [5:0]             bal_req;
    logic [9:0]             temp_cfg;
    logic [63:0]            cur_tab;
    logic [31:0]            volt;
    logic [4:0]             fail_code;
    logic [psc_pkg::CNT_W-1:0] ms_cnt;
    logic [9:0]             sub_ms;
    logic [15:0]            fast_s;
    logic [15:0]            life_s;
    logic [11:0]            low_ms;
    logic [15:0]            eoff_ms;
    psc_pkg::psc_eoff_t     eoff;
    logic                   eoff_prev;
    logic                   chg_fault;
    logic [psc_pkg::ACC_W-1:0] acc;
    logic                   chg_sw;
    logic                   dsg_sw;
    logic                   present;
    logic [5:0]             bal;
    logic                   scan;
    logic                   life_wr;
    logic                   fast_wr;
    logic                   boff;
    logic                   breq;
    logic [15:0]            bcur;
    logic                   c_alarm;
    logic                   d_alarm;
    logic [4:0]             led;
    logic                   chg_act;
    logic                   dsg_act;
  } psc_state_t;

  psc_state_t s_r;
  psc_state_t s_nxt;

  logic [3:0] pins_s;

  psc_sync #(.W(4)) u_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .d       ({system_present_input, emergency_off_input, bus_clock_line, bus_data_line}),
    .q       (pins_s)
  );

  // ----------------------------------------
  // Decoding helpers
  // ----------------------------------------
  function automatic logic [5:0] cell_mask(input logic [2:0] n);
    logic [5:0] m;
    m = '0;
    for (int i = 0; i < psc_pkg::MAX_CELLS; i++) begin
      m[i] = (3'(i) < n);
    end
    return m;
  endfunction

  function automatic logic [5:0] lowest_one(input logic [5:0] v);
    logic [5:0] r;
    logic       found;
    r     = '0;
    found = 1'b0;
    for (int i = 0; i < psc_pkg::MAX_CELLS; i++) begin
      if (v[i] && !found) begin
        r[i]  = 1'b1;
        found = 1'b1;
      end
    end
    return r;
  endfunction

  function automatic logic [4:0] seg_mask(input logic [2:0] n);
    logic [4:0] m;
    m = '0;
    for (int i = 0; i < psc_pkg::N_SEG; i++) begin
      m[i] = (3'(i) < n);
    end
    return m;
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  logic        ms_tick;
  logic        sec_tick;
  logic        eoff_fall;
  logic        acc_wr;
  logic        acc_rd;
  logic [31:0] rdata;
  logic        hit;
  logic [5:0]  bal_c;
  logic [9:0]  cap_x;
  logic [15:0] cur_sel;

  always_comb begin
    s_nxt = s_r;

    // Millisecond and second ticks
    ms_tick  = (s_r.ms_cnt == psc_pkg::CNT_W'(MS_CYC - 1));
    sec_tick = ms_tick && (s_r.sub_ms == 10'(psc_pkg::SEC_MS - 1));
    s_nxt.ms_cnt = ms_tick ? '0 : s_r.ms_cnt + 1'b1;
    if (ms_tick) begin
      s_nxt.sub_ms = sec_tick ? '0 : s_r.sub_ms + 1'b1;
    end

    // APB slave, one wait state
    acc_rd = psel && penable && !s_r.apb.pready;
    acc_wr = psel && penable && s_r.apb.pready && pwrite;
    s_nxt.apb.pready = acc_rd;
    hit   = 1'b1;
    rdata = '0;
    unique case (paddr)
      psc_pkg::A_CTRL:     rdata = 32'(s_r.ctrl);
      psc_pkg::A_STATUS:   rdata = {23'h0, s_r.chg_fault, s_r.eoff == psc_pkg::EO_OFF,
                                    s_r.boff, s_r.present, s_r.chg_act, s_r.dsg_act,
                                    s_r.chg_sw, s_r.dsg_sw, temp_in_range};
      psc_pkg::A_EOFF_TMO: rdata = 32'(s_r.eoff_tmo);
      psc_pkg::A_BAL_REQ:  rdata = {20'h0, s_r.bal, 6'(s_r.bal_req)};
      psc_pkg::A_TEMP_CFG: rdata = 32'(s_r.temp_cfg);
      psc_pkg::A_CUR_LO:   rdata = s_r.cur_tab[31:0];
      psc_pkg::A_CUR_HI:   rdata = s_r.cur_tab[63:32];
      psc_pkg::A_VOLT:     rdata = s_r.volt;
      psc_pkg::A_FAIL:     rdata = 32'(s_r.fail_code);
      psc_pkg::A_CHARGE:   rdata = s_r.acc;
      default:             hit = 1'b0;
    endcase
    if (acc_rd) begin
      s_nxt.apb.prdata  = pwrite ? '0 : rdata;
      s_nxt.apb.pslverr = !hit;
    end
    if (acc_wr && hit) begin
      unique case (paddr)
        psc_pkg::A_CTRL:     s_nxt.ctrl = psc_pkg::psc_ctrl_t'(pwdata[10:0]);
        psc_pkg::A_EOFF_TMO: s_nxt.eoff_tmo = pwdata[15:0];
        psc_pkg::A_BAL_REQ:  s_nxt.bal_req = pwdata[5:0];
        psc_pkg::A_TEMP_CFG: s_nxt.temp_cfg = pwdata[9:0];
        psc_pkg::A_CUR_LO:   s_nxt.cur_tab[31:0] = pwdata;
        psc_pkg::A_CUR_HI:   s_nxt.cur_tab[63:32] = pwdata;
        psc_pkg::A_VOLT:     s_nxt.volt = pwdata;
        psc_pkg::A_FAIL:     s_nxt.fail_code = pwdata[4:0];
        psc_pkg::A_STATUS: begin
          if (pwdata[psc_pkg::ST_FAULT]) begin
            s_nxt.chg_fault = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // System present sampling
    if (sec_tick) begin
      s_nxt.present = !pins_s[3];
    end

    // Emergency off
    s_nxt.eoff_prev = pins_s[2];
    eoff_fall = s_r.eoff_prev && !pins_s[2];
    unique case (s_r.eoff)
      psc_pkg::EO_RUN: begin
        if (eoff_fall) begin
          s_nxt.eoff    = psc_pkg::EO_OFF;
          s_nxt.eoff_ms = '0;
        end
      end
      psc_pkg::EO_OFF: begin
        if (eoff_fall) begin
          s_nxt.eoff = psc_pkg::EO_RUN;
        end else if (ms_tick) begin
          if (s_r.eoff_ms + 1'b1 >= s_r.eoff_tmo) begin
            s_nxt.eoff = psc_pkg::EO_RUN;
          end
          s_nxt.eoff_ms = s_r.eoff_ms + 1'b1;
        end
      end
    endcase
    s_nxt.dsg_sw = (s_nxt.eoff == psc_pkg::EO_RUN);
    s_nxt.chg_sw = (s_nxt.eoff == psc_pkg::EO_RUN) && temp_in_range;

    // Charge counting
    if (sense_valid) begin
      s_nxt.acc = s_r.acc + psc_pkg::ACC_W'(signed'(sense_voltage));
      s_nxt.chg_act = !sense_voltage[15] && (sense_voltage != '0);
      s_nxt.dsg_act = sense_voltage[15];
    end

    // Charging fault, set wins over clear
    if (s_r.chg_act && !s_r.chg_sw) begin
      s_nxt.chg_fault = 1'b1;
    end
    s_nxt.c_alarm = s_nxt.chg_fault || !temp_in_range;
    s_nxt.d_alarm = (s_nxt.eoff == psc_pkg::EO_OFF);

    // Cell balancing
    bal_c = s_r.bal_req & cell_mask(s_r.ctrl.cells);
    if (s_r.chg_act) begin
      bal_c = bal_c & cell_over_thr;
    end
    if (s_r.dsg_act) begin
      bal_c = '0;
    end
    s_nxt.bal = s_r.ctrl.ext_bal ? lowest_one(bal_c) : bal_c;

    // Periodic schedules
    s_nxt.scan    = sec_tick;
    s_nxt.life_wr = 1'b0;
    s_nxt.fast_wr = 1'b0;
    if (sec_tick) begin
      if (s_r.fast_s == 16'(LOG_FAST_S - 1)) begin
        s_nxt.fast_s  = '0;
        s_nxt.fast_wr = log_fast_dirty;
      end else begin
        s_nxt.fast_s = s_r.fast_s + 1'b1;
      end
      if (s_r.life_s == 16'(LOG_LIFE_S - 1)) begin
        s_nxt.life_s  = '0;
        s_nxt.life_wr = log_life_dirty;
      end else begin
        s_nxt.life_s = s_r.life_s + 1'b1;
      end
    end

    // Bus off detection
    if (pins_s[1] || pins_s[0]) begin
      s_nxt.low_ms = '0;
      s_nxt.boff   = 1'b0;
    end else if (ms_tick) begin
      if (s_r.low_ms >= 12'(psc_pkg::BUSOFF_MS)) begin
        s_nxt.boff = 1'b1;
      end else begin
        s_nxt.low_ms = s_r.low_ms + 1'b1;
      end
    end

    // Charger broadcast
    unique case (temp_range)
      2'h0:    cur_sel = s_r.cur_tab[15:0];
      2'h1:    cur_sel = s_r.cur_tab[31:16];
      2'h2:    cur_sel = s_r.cur_tab[47:32];
      default: cur_sel = s_r.cur_tab[63:48];
    endcase
    if (|(cell_over_thr & cell_mask(s_r.ctrl.cells))) begin
      cur_sel = s_r.volt[31:16];
    end
    if (!temp_in_range) begin
      cur_sel = '0;
    end
    s_nxt.breq = sec_tick && s_r.ctrl.bcast_en && !s_r.boff;
    if (sec_tick) begin
      s_nxt.bcur = cur_sel;
    end

    // Segment display
    for (int i = 0; i < psc_pkg::N_SEG; i++) begin
      cap_x = 10'(capacity_pct) * 10'(s_r.ctrl.segs);
      s_nxt.led[i] = cap_x > 10'(i * psc_pkg::PCT_FULL);
    end
    s_nxt.led = (s_r.ctrl.pf_mode ? s_r.fail_code : s_nxt.led)
                & seg_mask(s_r.ctrl.segs);
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r            <= '0;
      s_r.ctrl.cells <= psc_pkg::CELLS_RST;
      s_r.ctrl.segs  <= psc_pkg::SEGS_RST;
      s_r.eoff_tmo   <= psc_pkg::EOFF_TMO_RST;
      s_r.eoff       <= psc_pkg::EO_RUN;
      s_r.eoff_prev  <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign pready                 = s_r.apb.pready;
  assign prdata                 = s_r.apb.prdata;
  assign pslverr                = s_r.apb.pslverr;
  assign charge_switch_drive    = s_r.chg_sw;
  assign discharge_switch_drive = s_r.dsg_sw;
  assign system_present         = s_r.present;
  assign bal_en                 = s_r.bal;
  assign cell_scan_req          = s_r.scan;
  assign log_life_wr            = s_r.life_wr;
  assign log_fast_wr            = s_r.fast_wr;
  assign bus_off                = s_r.boff;
  assign temp_en                = s_r.temp_cfg[4:0];
  assign temp_is_fet            = s_r.temp_cfg[9:5];
  assign bcast_req              = s_r.breq;
  assign bcast_current          = s_r.bcur;
  assign bcast_voltage          = s_r.volt[15:0];
  assign charge_alarm           = s_r.c_alarm;
  assign discharge_alarm        = s_r.d_alarm;
  assign led_seg                = s_r.led;
  assign bus_master_en          = s_r.ctrl.master_en;
  assign pec_en                 = s_r.ctrl.pec_en;
  assign charge_active          = s_r.chg_act;
  assign discharge_active       = s_r.dsg_act;

endmodule

// File: sim/psc_checker.sv
// Port assertions for the pack supervisor control block
`timescale 1ns/100ps
module psc_checker #(
  parameter int unsigned MS_CYC = 10
) (
  input wire logic        sys_clk,                // Clock
  input wire logic        rst_n,                  // Reset
  input wire logic        emergency_off_input,    // Pin
  input wire logic        bus_clock_line,         // Pin
  input wire logic        bus_data_line,          // Pin
  input wire logic [15:0] sense_voltage,          // Sample
  input wire logic        sense_valid,            // Strobe
  input wire logic        temp_in_range,          // Level
  input wire logic        log_life_dirty,         // Level
  input wire logic        log_fast_dirty,         // Level
  input wire logic        charge_switch_drive,    // Drive
  input wire logic        discharge_switch_drive, // Drive
  input wire logic        cell_scan_req,          // Pulse
  input wire logic        log_life_wr,            // Pulse
  input wire logic        log_fast_wr,            // Pulse
  input wire logic        bus_off,                // State
  input wire logic        bcast_req,              // Pulse
  input wire logic        charge_active,          // Flag
  input wire logic        discharge_active        // Flag
);
  localparam int unsigned SEC    = psc_pkg::SEC_MS * MS_CYC;
  localparam int unsigned OFF_LO = psc_pkg::BUSOFF_MS * MS_CYC;
  localparam int unsigned OFF_HI = (psc_pkg::BUSOFF_MS + 2) * MS_CYC;
  logic [31:0] low_r;
  logic [31:0] gap_r;
  logic        seen_r;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // ----
  // Raw-pin low time and scan spacing
  // ----
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_r  <= 32'h0;
      gap_r  <= 32'h0;
      seen_r <= 1'h0;
    end else begin
      low_r  <= (bus_clock_line | bus_data_line) ? 32'h0 : low_r + 32'h1;
      gap_r  <= cell_scan_req ? 32'h1 : gap_r + 32'h1;
      seen_r <= seen_r | cell_scan_req;
    end
  end

  AST_EOFF_OFF: assert property (
    $fell(emergency_off_input) && discharge_switch_drive
    |-> ##[1:7] (!discharge_switch_drive && !charge_switch_drive)) else $error("drives stay on");
  AST_EOFF_ON: assert property (
    $fell(emergency_off_input) && !discharge_switch_drive |-> ##[1:7] discharge_switch_drive)
    else $error("drives stay off");
  AST_TEMP_INHIBIT: assert property (
    !temp_in_range [*6] |-> !charge_switch_drive) else $error("charge on out of range");
  AST_BUSOFF_EARLY: assert property (
    $rose(bus_off) |-> low_r >= OFF_LO) else $error("bus off too early");
  AST_BUSOFF_LATE: assert property (
    low_r > OFF_HI |-> bus_off) else $error("bus off missing");
  AST_BUSOFF_EXIT: assert property (
    bus_off && (bus_clock_line || bus_data_line) |-> ##[1:6] !bus_off)
    else $error("bus off not left");
  AST_SCAN_PERIOD: assert property (
    cell_scan_req && seen_r |-> gap_r == SEC) else $error("scan period wrong");
  AST_CHG_DIR: assert property (
    sense_valid && $signed(sense_voltage) > 0 |=> charge_active && !discharge_active)
    else $error("charge not flagged");
  AST_DSG_DIR: assert property (
    sense_valid && $signed(sense_voltage) < 0 |=> discharge_active && !charge_active)
    else $error("discharge not flagged");
  AST_LIFE_DIRTY: assert property (
    log_life_wr |-> $past(log_life_dirty)) else $error("clean lifetime write");
  AST_FAST_DIRTY: assert property (
    log_fast_wr |-> $past(log_fast_dirty)) else $error("clean fast write");

  cover property (bus_off);
  cover property (bcast_req);
  cover property ($fell(discharge_switch_drive));
endmodule

bind psc_top psc_checker #(.MS_CYC(MS_CYC)) u_chk (.*);

// File: sim/psc_bus_model.sv
// Far-side model: host and charger levels on the two bus lines
`timescale 1ns/100ps
module psc_bus_model (
  input  wire logic frame,    // Host runs a frame
  input  wire logic hold_low, // Host holds both lines low
  output logic      scl,      // Bus clock line level
  output logic      sda       // Bus data line level
);
  logic clk_r = 1'h1;
  logic dat_r = 1'h1;

  always #32 clk_r = frame ? ~clk_r : 1'h1;
  always @(negedge clk_r) dat_r = ~dat_r;
  // Pull-ups idle both lines high
  assign scl = hold_low ? 1'h0 : clk_r;
  assign sda = hold_low ? 1'h0 : (frame ? dat_r : 1'h1);
endmodule

// File: sim/tb_top.sv
// Testbench for the pack supervisor control block
`timescale 1ns/100ps
module tb_top;
  localparam int unsigned MS = 10;
  logic        sys_clk = 1'h0;
  logic        rst_n = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic        system_present_input = 1'h1;
  logic        emergency_off_input = 1'h1;
  logic [15:0] sense_voltage = 16'h0;
  logic        sense_valid = 1'h0;
  logic [5:0]  cell_over_thr = 6'h0;
  logic        temp_in_range = 1'h1;
  logic [1:0]  temp_range = 2'h0;
  logic [6:0]  capacity_pct = 7'h32;
  logic        log_life_dirty = 1'h1;
  logic        log_fast_dirty = 1'h1;
  logic        frame = 1'h0;
  logic        hold = 1'h0;
  logic        bus_clock_line, bus_data_line, pready, pslverr, system_present, rerr;
  logic        charge_switch_drive, discharge_switch_drive, cell_scan_req, log_life_wr;
  logic        log_fast_wr, bus_off, bcast_req, charge_alarm, discharge_alarm;
  logic        bus_master_en, pec_en, charge_active, discharge_active;
  logic [31:0] prdata, rdat;
  logic [31:0] acc = 32'h0;
  logic [5:0]  bal_en;
  logic [4:0]  temp_en, temp_is_fet, led_seg;
  logic [15:0] bcast_current, bcast_voltage;
  int          fail_count = 0, n_checks = 0, secs = 0, fast_n = 0, life_n = 0;

  psc_top #(.MS_CYC(MS), .LOG_FAST_S(3), .LOG_LIFE_S(5)) u_dut (.*);
  psc_bus_model u_bus (.frame(frame), .hold_low(hold), .scl(bus_clock_line),
                       .sda(bus_data_line));

  always #4 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    if (cell_scan_req === 1'h1) secs++;
    if (log_fast_wr === 1'h1) fast_n++;
    if (log_life_wr === 1'h1) life_n++;
    log_fast_dirty <= (secs < 4);
  end

  // ----
  // Bus and compare tasks
  // ----
  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge sys_clk);
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    psel    <= 1'h1;
    penable <= 1'h0;
    @(posedge sys_clk);
    penable <= 1'h1;
    do @(posedge sys_clk); while (pready !== 1'h1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic smp(input logic [15:0] v);
    @(posedge sys_clk);
    sense_voltage <= v;
    sense_valid   <= 1'h1;
    acc += {{16{v[15]}}, v};
    @(posedge sys_clk);
    sense_valid <= 1'h0;
  endtask

  task automatic eo;
    @(posedge sys_clk);
    emergency_off_input <= 1'h0;
    cyc(10);
    emergency_off_input <= 1'h1;
    cyc(4);
  endtask

  task automatic wb;
    int i;
    cyc(2);
    for (i = 0; i < 12000 && bcast_req !== 1'h1; i++) @(posedge sys_clk);
    ck(32'(bcast_req), 32'h1);
  endtask

  task automatic complete_run;
    if (fail_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ----
  // Tests
  // ----
  initial begin
    cyc(3);
    rst_n <= 1'h1;
    apb(psc_pkg::A_CTRL, 1'h0, 32'h0);
    ck(rdat, 32'h35);
    apb(psc_pkg::A_EOFF_TMO, 1'h0, 32'h0);
    ck(rdat, 32'h2710);
    apb(8'h40, 1'h0, 32'h0);
    ck(32'(rerr), 32'h1);
    ck(32'(led_seg), 32'h07);
    apb(psc_pkg::A_FAIL, 1'h1, 32'h15);
    apb(psc_pkg::A_CTRL, 1'h1, 32'h75);
    cyc(4);
    ck(32'(led_seg), 32'h15);
    apb(psc_pkg::A_CTRL, 1'h1, 32'h2b);
    apb(psc_pkg::A_TEMP_CFG, 1'h1, 32'h345);
    apb(psc_pkg::A_BAL_REQ, 1'h1, 32'h3f);
    cyc(4);
    ck(32'(led_seg), 32'h03);
    ck(32'({temp_is_fet, temp_en}), 32'h345);
    ck(32'(bal_en), 32'h1f);
    apb(psc_pkg::A_CTRL, 1'h1, 32'h433);
    cyc(4);
    ck(32'(bal_en), 32'h01);
    apb(psc_pkg::A_CTRL, 1'h1, 32'h33);
    cell_over_thr <= 6'h24;
    smp(16'h0100);
    cyc(4);
    ck(32'(bal_en), 32'h24);
    ck(32'({charge_active, discharge_active}), 32'h2);
    smp(16'hff80);
    cyc(4);
    ck(32'({charge_active, discharge_active, bal_en}), 32'h40);
    apb(psc_pkg::A_CHARGE, 1'h0, 32'h0);
    ck(rdat, acc);
    cell_over_thr <= 6'h00;
    apb(psc_pkg::A_EOFF_TMO, 1'h1, 32'h8);
    eo();
    ck(32'({charge_switch_drive, discharge_switch_drive, discharge_alarm}), 32'h1);
    eo();
    ck(32'({charge_switch_drive, discharge_switch_drive, discharge_alarm}), 32'h6);
    eo();
    cyc(30);
    ck(32'({charge_switch_drive, discharge_switch_drive}), 32'h0);
    cyc(60);
    ck(32'({charge_switch_drive, discharge_switch_drive}), 32'h3);
    temp_in_range <= 1'h0;
    cyc(8);
    ck(32'({charge_switch_drive, charge_alarm}), 32'h1);
    temp_in_range <= 1'h1;
    frame <= 1'h1;
    cyc(200);
    frame <= 1'h0;
    hold  <= 1'h1;
    cyc(19980);
    ck(32'(bus_off), 32'h0);
    cyc(60);
    ck(32'(bus_off), 32'h1);
    hold <= 1'h0;
    cyc(8);
    ck(32'(bus_off), 32'h0);
    system_present_input <= 1'h0;
    apb(psc_pkg::A_CUR_LO, 1'h1, 32'h0200_0100);
    apb(psc_pkg::A_VOLT, 1'h1, 32'h0050_3000);
    apb(psc_pkg::A_CTRL, 1'h1, 32'h3b5);
    temp_range <= 2'h1;
    cyc(4);
    ck(32'({bus_master_en, pec_en}), 32'h3);
    wb();
    ck({bcast_current, bcast_voltage}, 32'h0200_3000);
    cyc(20);
    ck(32'(system_present), 32'h1);
    cell_over_thr <= 6'h01;
    wb();
    ck(32'(bcast_current), 32'h0050);
    apb(psc_pkg::A_CUR_HI, 1'h1, 32'h0400_0300);
    cell_over_thr <= 6'h00;
    temp_range <= 2'h3;
    wb();
    ck(32'(bcast_current), 32'h0400);
    temp_in_range <= 1'h0;
    wb();
    ck(32'(bcast_current), 32'h0);
    smp(16'h0010);
    apb(psc_pkg::A_STATUS, 1'h0, 32'h0);
    ck(rdat, 32'h132);
    temp_in_range <= 1'h1;
    apb(psc_pkg::A_STATUS, 1'h1, 32'h100);
    apb(psc_pkg::A_STATUS, 1'h0, 32'h0);
    ck(rdat, 32'h37);
    cyc(100);
    ck(32'(fast_n), 32'h1);
    ck(32'(life_n), 32'(secs / 5));
    complete_run();
  end

  initial begin
    cyc(90000);
    fail_count++;
    complete_run();
  end
endmodule
